// ---- core/pbpi_bus_if.sv ----
// Shared picture bus joining the video processor end and a feature source end.
`timescale 1ns/100ps
`default_nettype none
interface pbpi_bus_if import pbpi_pkg::*; ();
	logic pix_strobe;
	logic main_line_sync;
	logic [SOURCE_PRIORITY_BUS_W-1:0] dev_source_priority_bus;
	logic dev_source_priority_bus_oe;
	logic [SOURCE_PRIORITY_BUS_W-1:0] src_source_priority_bus;
	logic src_source_priority_bus_oe;
	logic [YC_W-1:0] dev_yc;
	logic dev_yc_oe;
	logic [YC_W-1:0] src_yc;
	logic src_yc_oe;
	logic [RGB_W-1:0] src_rgb;
	logic src_rgb_oe;
	logic [SOURCE_PRIORITY_BUS_W-1:0] source_priority_bus;
	logic [YC_W-1:0] yc_bus;
	logic [RGB_W-1:0] rgb_bus;
	logic rgb_valid;
	// The highest identifier among the drivers is what every master reads back.
	assign source_priority_bus = (dev_source_priority_bus_oe && (!src_source_priority_bus_oe || dev_source_priority_bus >= src_source_priority_bus)) ?
		dev_source_priority_bus : (src_source_priority_bus_oe ? src_source_priority_bus : '0);
	assign yc_bus = dev_yc_oe ? dev_yc : (src_yc_oe ? src_yc : '0);
	assign rgb_bus = src_rgb_oe ? src_rgb : '0;
	assign rgb_valid = src_rgb_oe;
	modport device (output pix_strobe, main_line_sync, dev_source_priority_bus, dev_source_priority_bus_oe, dev_yc, dev_yc_oe,
		input source_priority_bus, yc_bus, rgb_bus, rgb_valid);
	modport source (input pix_strobe, main_line_sync, source_priority_bus,
		output src_source_priority_bus, src_source_priority_bus_oe, src_yc, src_yc_oe, src_rgb, src_rgb_oe);
endinterface
`default_nettype wire

// ---- core/pbpi_device_end.sv ----
// Video processor end: YCrCb coding, delay FIFO, main sync, arbitration and insertion.
// Summary of operation
// - Bus carries active-video YCrCb at 20.25 Ms/s.
// - Main line sync marks start of valid data.
// - Exactly 1068 active samples every line.
// - Main sync carries line number and field serially.
// - Luma code is 224 times luma plus 16.
// - Chroma codes weighted, times 224, plus 128.
// - Option switches chroma to two's complement.
// - FIFO stores only samples inside front-end window.
// - FIFO read under display main sync, delay adjustable.
// - Buses: 16-bit YCrCb, 5-bit RGB, 3-bit priority.
// - Priority bus mixes up to eight sources.
// - RGB bits: three colour bits, half-contrast bit.
// - Fifth bit selects 16-entry 4-bit lookup table.
// - Inserted RGB passes with no filtering.
// - Three separate contrast multipliers scale RGB.
// - Master drives its identifier, reads bus back.
// - Acknowledge and data only when identifiers match.
// - Request from software or fast-blank input.
// - Configured priorities prevent two simultaneous data drivers.
// - Arbitration per pixel; sources sample-synchronous.
// - Coefficients chosen by which source holds bus.
`timescale 1ns/100ps
`default_nettype none
module pbpi_device_end import pbpi_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Picture bus
	pbpi_bus_if.device bus,
	// Decoder samples
	input wire logic dec_valid,
	input wire logic [7:0] dec_y,
	input wire logic signed [7:0] dec_c,
	input wire logic dec_c_is_cr,
	input wire logic fe_active,
	output logic dec_ready,
	// Display timing
	input wire logic disp_line_start,
	input wire logic disp_field_start,
	input wire logic disp_field_odd,
	// Configuration
	input wire logic chroma_twos,
	input wire logic [SOURCE_PRIORITY_BUS_W-1:0] dev_id,
	input wire logic dev_sw_req,
	input wire logic fast_blank,
	input wire logic [CONTRAST_W-1:0] main_contrast,
	input wire logic [CONTRAST_W-1:0] side_contrast,
	input wire logic [CONTRAST_W-1:0] rgb_contrast [RGB_COLOURS],
	input wire logic colour_lookup_table_we,
	input wire logic [3:0] colour_lookup_table_idx,
	input wire logic [RGB_COLOURS*COLOUR_LOOKUP_TABLE_RES-1:0] colour_lookup_table_data,
	// Display output
	output logic disp_valid,
	output logic [SOURCE_PRIORITY_BUS_W-1:0] disp_src,
	output logic disp_is_rgb,
	output logic [7:0] disp_y,
	output logic [7:0] disp_c,
	output logic [7:0] disp_rgb [RGB_COLOURS],
	output logic dev_ack,
	output logic fifo_underrun
);
	logic [PH_W-1:0] ph_r;
	logic [PH_W-1:0] ph_sum;
	logic strobe_r;
	logic strobe_d_r;
	logic fb_s1_r;
	logic fb_s2_r;
	logic [15:0] y_prod;
	logic [7:0] y_code;
	logic [7:0] c_weight;
	logic signed [25:0] c_prod;
	logic [7:0] c_scaled;
	logic [7:0] c_code;
	logic f_valid;
	logic [YC_W-1:0] f_data;
	logic f_pop;
	pbpi_line_t state_r;
	logic [PIX_W-1:0] pix_r;
	logic [LINE_W-1:0] line_r;
	logic [INFO_BITS-1:0] info_r;
	logic [INFO_CW-1:0] info_cnt_r;
	logic msy_r;
	logic [SOURCE_PRIORITY_BUS_W-1:0] source_priority_bus_r;
	logic source_priority_bus_oe_r;
	logic [YC_W-1:0] yc_r;
	logic yc_oe_r;
	logic [YC_W-1:0] word_r;
	logic [COLOUR_LOOKUP_TABLE_RES-1:0] colour_lookup_table_r [COLOUR_LOOKUP_TABLE_ENTRIES][RGB_COLOURS];
	logic [CONTRAST_W-1:0] y_gain;
	logic [13:0] y_adj;
	logic pend_r;
	// Pixel strobe from a phase accumulator, 81 strobes per 800 clocks on average.
	assign ph_sum = ph_r + PH_STEP;
	always_ff @(posedge clk) begin
		if (rst) begin
			ph_r <= '0;
			strobe_r <= 1'b0;
			strobe_d_r <= 1'b0;
		end else begin
			ph_r <= (ph_sum >= PH_MOD) ? ph_sum - PH_MOD : ph_sum;
			strobe_r <= ph_sum >= PH_MOD;
			strobe_d_r <= strobe_r;
		end
	end
	assign bus.pix_strobe = strobe_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			fb_s1_r <= 1'b0;
			fb_s2_r <= 1'b0;
		end else begin
			fb_s1_r <= fast_blank;
			fb_s2_r <= fb_s1_r;
		end
	end
	// Sample coding; the chroma input must stay inside the legal colour-difference range.
	assign y_prod = dec_y * CODE_GAIN;
	assign y_code = y_prod[15:8] + CODE_OFS_Y;
	assign c_weight = dec_c_is_cr ? WEIGHT_CR_Q8 : WEIGHT_CB_Q8;
	assign c_prod = dec_c * $signed({1'b0, c_weight}) * $signed({1'b0, CODE_GAIN});
	assign c_scaled = c_prod[C_SHIFT+7:C_SHIFT];
	assign c_code = chroma_twos ? c_scaled : c_scaled + CODE_OFS_C;
	// Writes outside the front-end window are dropped, not held.
	pbpi_fifo #(
		.WIDTH(YC_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(dec_valid && fe_active),
		.in_data({y_code, c_code}),
		.in_ready(dec_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_pop)
	);
	assign f_pop = strobe_r && state_r == PBPI_ACTIVE;
	// Line sequencing under display timing.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= PBPI_IDLE;
			pix_r <= '0;
		end else begin
			case (state_r)
				PBPI_IDLE: begin
					if (disp_line_start) begin
						state_r <= PBPI_SYNC;
					end
				end
				PBPI_SYNC: begin
					if (strobe_r) begin
						state_r <= PBPI_ACTIVE;
						pix_r <= '0;
					end
				end
				PBPI_ACTIVE: begin
					if (strobe_r) begin
						pix_r <= pix_r + 1'b1;
						if (pix_r == ACTIVE_SAMPLES - 1'b1) begin
							state_r <= PBPI_IDLE;
						end
					end
				end
				default: begin
					state_r <= PBPI_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			line_r <= FIRST_LINE;
		end else if (disp_field_start) begin
			line_r <= FIRST_LINE;
		end else if (state_r == PBPI_SYNC && strobe_r) begin
			// Advance after capture, so the first line after reset or field start is line one.
			line_r <= line_r + 1'b1;
		end
	end
	// Sync pulse for one sample period, then field and line number, MSB first.
	always_ff @(posedge clk) begin
		if (rst) begin
			msy_r <= 1'b0;
			info_r <= '0;
			info_cnt_r <= '0;
		end else if (state_r == PBPI_SYNC && strobe_r) begin
			msy_r <= 1'b1;
			info_r <= {disp_field_odd, line_r};
			info_cnt_r <= INFO_LAST;
		end else if (strobe_r) begin
			msy_r <= (info_cnt_r != '0) && info_r[INFO_BITS-1];
			info_r <= {info_r[INFO_BITS-2:0], 1'b0};
			info_cnt_r <= (info_cnt_r != '0) ? info_cnt_r - 1'b1 : '0;
		end
	end
	assign bus.main_line_sync = msy_r;
	// Request on each strobe, acknowledge one clock later from the value read back.
	always_ff @(posedge clk) begin
		if (rst) begin
			source_priority_bus_r <= '0;
			source_priority_bus_oe_r <= 1'b0;
			yc_r <= '0;
			yc_oe_r <= 1'b0;
			dev_ack <= 1'b0;
			word_r <= '0;
			fifo_underrun <= 1'b0;
		end else begin
			if (strobe_r) begin
				source_priority_bus_r <= dev_id;
				source_priority_bus_oe_r <= state_r == PBPI_ACTIVE && (dev_sw_req || fb_s2_r);
				word_r <= f_valid ? f_data : {CODE_OFS_Y, chroma_twos ? 8'h00 : CODE_OFS_C};
				if (state_r == PBPI_ACTIVE && !f_valid) begin
					fifo_underrun <= 1'b1;
				end
			end
			if (strobe_d_r) begin
				dev_ack <= source_priority_bus_oe_r && bus.source_priority_bus == source_priority_bus_r;
				yc_oe_r <= source_priority_bus_oe_r && bus.source_priority_bus == source_priority_bus_r;
				yc_r <= word_r;
			end
		end
	end
	assign bus.dev_source_priority_bus = source_priority_bus_r;
	assign bus.dev_source_priority_bus_oe = source_priority_bus_oe_r;
	assign bus.dev_yc = yc_r;
	assign bus.dev_yc_oe = yc_oe_r;
	always_ff @(posedge clk) begin
		if (colour_lookup_table_we) begin
			colour_lookup_table_r[colour_lookup_table_idx][0] <= colour_lookup_table_data[COLOUR_LOOKUP_TABLE_RES-1:0];
			colour_lookup_table_r[colour_lookup_table_idx][1] <= colour_lookup_table_data[2*COLOUR_LOOKUP_TABLE_RES-1:COLOUR_LOOKUP_TABLE_RES];
			colour_lookup_table_r[colour_lookup_table_idx][2] <= colour_lookup_table_data[3*COLOUR_LOOKUP_TABLE_RES-1:2*COLOUR_LOOKUP_TABLE_RES];
		end
	end
	// The completed pixel is taken from the bus at the next strobe.
	assign y_gain = (bus.source_priority_bus == dev_id) ? main_contrast : side_contrast;
	assign y_adj = (bus.yc_bus[YC_W-1:8] * y_gain) >> CONTRAST_SHIFT;
	always_ff @(posedge clk) begin
		if (rst) begin
			disp_valid <= 1'b0;
			pend_r <= 1'b0;
			disp_src <= '0;
			disp_is_rgb <= 1'b0;
			disp_y <= '0;
			disp_c <= '0;
		end else begin
			// Strobes run through blanking; only those closing a pixel of the active line are valid, requested or not.
			disp_valid <= strobe_r && pend_r;
			if (strobe_r) begin
				pend_r <= state_r == PBPI_ACTIVE;
				disp_src <= bus.source_priority_bus;
				disp_is_rgb <= bus.rgb_valid;
				disp_y <= (y_adj[13:8] != '0) ? Y_MAX : y_adj[7:0];
				disp_c <= bus.yc_bus[7:0];
			end
		end
	end
	for (genvar k = 0; k < RGB_COLOURS; k++) begin : g_rgb
		logic [COLOUR_LOOKUP_TABLE_RES-1:0] lvl;
		logic [COLOUR_LOOKUP_TABLE_RES+CONTRAST_W-1:0] scaled;
		always_comb begin
			lvl = '0;
			if (bus.rgb_bus[RGB_COLOUR_LOOKUP_TABLE_BIT]) begin
				lvl = colour_lookup_table_r[bus.rgb_bus[COLOUR_LOOKUP_TABLE_RES-1:0]][k];
			end else if (bus.rgb_bus[k]) begin
				lvl = bus.rgb_bus[RGB_HALF_BIT] ? LVL_HALF : LVL_FULL;
			end
		end
		assign scaled = lvl * rgb_contrast[k];
		always_ff @(posedge clk) begin
			if (rst) begin
				disp_rgb[k] <= '0;
			end else if (strobe_r) begin
				disp_rgb[k] <= scaled[COLOUR_LOOKUP_TABLE_RES+CONTRAST_W-1:COLOUR_LOOKUP_TABLE_RES+CONTRAST_W-8];
			end
		end
	end
endmodule // pbpi_device_end
`default_nettype wire

// ---- core/pbpi_fifo.sv ----
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module pbpi_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] count_r;
	logic [AW:0] count_nxt;
	logic push;
	logic pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_r[rd_r];
	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
			count_r <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
			end
			count_r <= count_nxt;
			in_ready <= count_nxt != FULL;
			out_valid <= count_nxt != '0;
		end
	end
endmodule // pbpi_fifo
`default_nettype wire

// ---- core/pbpi_pkg.sv ----
// Constants and types shared by both ends of the picture bus priority interface.
package pbpi_pkg;
	localparam int unsigned CLK_RATE_KHZ = 200000;
	// Sample rate of the picture bus, 20.25 Msamples/s.
	localparam int unsigned SAMPLE_RATE_KHZ = 20250;
	localparam int unsigned PH_W = 18;
	localparam logic [PH_W-1:0] PH_STEP = PH_W'(SAMPLE_RATE_KHZ);
	localparam logic [PH_W-1:0] PH_MOD = PH_W'(CLK_RATE_KHZ);
	localparam int unsigned PIX_W = 11;
	localparam logic [PIX_W-1:0] ACTIVE_SAMPLES = 11'h42c;
	localparam int unsigned LINE_W = 10;
	localparam logic [LINE_W-1:0] FIRST_LINE = 10'h001;
	localparam int unsigned INFO_BITS = LINE_W + 1;
	localparam int unsigned INFO_CW = 4;
	localparam logic [INFO_CW-1:0] INFO_LAST = 4'(INFO_BITS);
	localparam int unsigned YC_W = 16;
	localparam int unsigned RGB_W = 5;
	localparam int unsigned SOURCE_PRIORITY_BUS_W = 3;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam logic [7:0] CODE_GAIN = 8'he0;
	localparam logic [7:0] CODE_OFS_Y = 8'h10;
	localparam logic [7:0] CODE_OFS_C = 8'h80;
	// Colour weights 0.713 and 0.564 in units of 1/256.
	localparam logic [7:0] WEIGHT_CR_Q8 = 8'hb7;
	localparam logic [7:0] WEIGHT_CB_Q8 = 8'h90;
	localparam int unsigned C_SHIFT = 15;
	localparam int unsigned RGB_COLOURS = 3;
	localparam int unsigned RGB_HALF_BIT = 3;
	localparam int unsigned RGB_COLOUR_LOOKUP_TABLE_BIT = 4;
	localparam int unsigned COLOUR_LOOKUP_TABLE_ENTRIES = 16;
	localparam int unsigned COLOUR_LOOKUP_TABLE_RES = 4;
	localparam logic [COLOUR_LOOKUP_TABLE_RES-1:0] LVL_FULL = 4'hf;
	localparam logic [COLOUR_LOOKUP_TABLE_RES-1:0] LVL_HALF = 4'h7;
	localparam int unsigned CONTRAST_W = 6;
	localparam int unsigned CONTRAST_SHIFT = 5;
	localparam logic [7:0] Y_MAX = 8'hff;
	typedef enum logic [1:0] {
		PBPI_IDLE = 2'b00,
		PBPI_SYNC = 2'b01,
		PBPI_ACTIVE = 2'b11
	} pbpi_line_t;
endpackage

// ---- core/pbpi_source_end.sv ----
// Feature source end: follows the main sync, arbitrates per pixel and inserts data.
`timescale 1ns/100ps
`default_nettype none
module pbpi_source_end import pbpi_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Picture bus
	pbpi_bus_if.source bus,
	// Source configuration and data
	input wire logic [SOURCE_PRIORITY_BUS_W-1:0] src_id,
	input wire logic src_sw_req,
	input wire logic fast_blank,
	input wire logic src_is_rgb,
	input wire logic [YC_W-1:0] src_yc,
	input wire logic [RGB_W-1:0] src_rgb,
	// Timing seen from the main sync
	output logic line_start,
	output logic [LINE_W-1:0] line_no,
	output logic field_odd,
	output logic [PIX_W-1:0] pix_idx,
	output logic src_ack
);
	logic fb_s1_r;
	logic fb_s2_r;
	logic strobe_d_r;
	logic msy_prev_r;
	logic active_r;
	logic [INFO_BITS-1:0] info_r;
	logic [INFO_CW-1:0] info_cnt_r;
	logic [SOURCE_PRIORITY_BUS_W-1:0] source_priority_bus_r;
	logic source_priority_bus_oe_r;
	logic data_oe_r;
	logic [YC_W-1:0] yc_r;
	logic [RGB_W-1:0] rgb_r;
	logic rgb_sel_r;
	logic win;
	always_ff @(posedge clk) begin
		if (rst) begin
			fb_s1_r <= 1'b0;
			fb_s2_r <= 1'b0;
			strobe_d_r <= 1'b0;
		end else begin
			fb_s1_r <= fast_blank;
			fb_s2_r <= fb_s1_r;
			strobe_d_r <= bus.pix_strobe;
		end
	end
	// A rising main sync starts the line; the following bits carry field and line number.
	always_ff @(posedge clk) begin
		if (rst) begin
			msy_prev_r <= 1'b0;
			line_start <= 1'b0;
			active_r <= 1'b0;
			pix_idx <= '0;
			info_r <= '0;
			info_cnt_r <= '0;
			line_no <= '0;
			field_odd <= 1'b0;
		end else begin
			line_start <= 1'b0;
			if (bus.pix_strobe) begin
				msy_prev_r <= bus.main_line_sync;
				if (bus.main_line_sync && !msy_prev_r && info_cnt_r == '0) begin
					line_start <= 1'b1;
					active_r <= 1'b1;
					pix_idx <= '0;
					info_cnt_r <= INFO_LAST;
				end else begin
					if (active_r) begin
						pix_idx <= pix_idx + 1'b1;
						active_r <= pix_idx != ACTIVE_SAMPLES - 1'b1;
					end
					if (info_cnt_r != '0) begin
						info_r <= {info_r[INFO_BITS-2:0], bus.main_line_sync};
						info_cnt_r <= info_cnt_r - 1'b1;
					end
					if (info_cnt_r == 4'h1) begin
						{field_odd, line_no} <= {info_r[INFO_BITS-2:0], bus.main_line_sync};
					end
				end
			end
		end
	end
	// The pixel window opens on the sync strobe itself, matching the device read.
	assign win = bus.main_line_sync && !msy_prev_r && info_cnt_r == '0 ||
		active_r && pix_idx != ACTIVE_SAMPLES - 1'b1;
	always_ff @(posedge clk) begin
		if (rst) begin
			source_priority_bus_r <= '0;
			source_priority_bus_oe_r <= 1'b0;
			data_oe_r <= 1'b0;
			src_ack <= 1'b0;
			yc_r <= '0;
			rgb_r <= '0;
			rgb_sel_r <= 1'b0;
		end else begin
			if (bus.pix_strobe) begin
				source_priority_bus_r <= src_id;
				source_priority_bus_oe_r <= win && (src_sw_req || fb_s2_r);
				yc_r <= src_yc;
				rgb_r <= src_rgb;
				rgb_sel_r <= src_is_rgb;
			end
			if (strobe_d_r) begin
				src_ack <= source_priority_bus_oe_r && bus.source_priority_bus == source_priority_bus_r;
				data_oe_r <= source_priority_bus_oe_r && bus.source_priority_bus == source_priority_bus_r;
			end
		end
	end
	assign bus.src_source_priority_bus = source_priority_bus_r;
	assign bus.src_source_priority_bus_oe = source_priority_bus_oe_r;
	assign bus.src_yc = yc_r;
	assign bus.src_yc_oe = data_oe_r && !rgb_sel_r;
	assign bus.src_rgb = rgb_r;
	assign bus.src_rgb_oe = data_oe_r && rgb_sel_r;
endmodule // pbpi_source_end
`default_nettype wire

// ---- verification/pbpi_bus_chk.sv ----
// Concurrent checks on the picture bus between the device end and the source end.
`timescale 1ns/100ps
`default_nettype none
module pbpi_bus_chk import pbpi_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus signals
	input wire logic pix_strobe,
	input wire logic main_line_sync,
	input wire logic [SOURCE_PRIORITY_BUS_W-1:0] dev_source_priority_bus,
	input wire logic dev_source_priority_bus_oe,
	input wire logic [SOURCE_PRIORITY_BUS_W-1:0] src_source_priority_bus,
	input wire logic src_source_priority_bus_oe,
	input wire logic dev_yc_oe,
	input wire logic src_yc_oe,
	input wire logic src_rgb_oe,
	input wire logic [SOURCE_PRIORITY_BUS_W-1:0] source_priority_bus
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic dev_win;
	logic src_win;
	logic src_data;
	assign dev_win = dev_source_priority_bus_oe && (source_priority_bus == dev_source_priority_bus);
	assign src_win = src_source_priority_bus_oe && (source_priority_bus == src_source_priority_bus);
	assign src_data = src_yc_oe || src_rgb_oe;
	chk_strobe_gap: assert property (pix_strobe |=> !pix_strobe[*8] ##[1:2] pix_strobe)
		else $error("sample strobe spacing is not 9 or 10 clocks");
	chk_sync_per_pixel: assert property ($changed(main_line_sync) |-> $past(pix_strobe))
		else $error("main line sync changed away from a strobe");
	chk_dev_won: assert property ($past(pix_strobe) && dev_win |=> dev_yc_oe)
		else $error("device won arbitration but drives no data");
	chk_dev_lost: assert property ($past(pix_strobe) && !dev_win |=> !dev_yc_oe)
		else $error("device drives data without winning");
	chk_src_won: assert property ($past(pix_strobe) && src_win |=> src_data)
		else $error("source won arbitration but drives no data");
	chk_src_lost: assert property ($past(pix_strobe) && !src_win |=> !src_data)
		else $error("source drives data without winning");
	chk_no_collision: assert property (dev_source_priority_bus != src_source_priority_bus |-> !(dev_yc_oe && src_data))
		else $error("both ends drive pixel data at once");
	chk_data_stands: assert property ($changed(dev_yc_oe) || $changed(src_data)
		|-> $past(pix_strobe, 2))
		else $error("data drive changed outside the pixel boundary");
	cover property ($past(pix_strobe) && dev_win);
	cover property ($past(pix_strobe) && src_win);
	cover property (dev_source_priority_bus_oe && src_source_priority_bus_oe);
endmodule // pbpi_bus_chk
`default_nettype wire

// ---- verification/picture_bus_priority_interface_bench.sv ----
// Self-checking bench joining the device end and the source end over the picture bus.
`timescale 1ns/100ps
`default_nettype none
module picture_bus_priority_interface_bench import pbpi_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic dec_valid = 1'b0;
	logic [7:0] dec_y = 8'h00;
	logic signed [7:0] dec_c = 8'h00;
	logic dec_c_is_cr = 1'b0;
	logic fe_active = 1'b0;
	logic dec_ready;
	logic disp_line_start = 1'b0;
	logic disp_field_start = 1'b0;
	logic disp_field_odd = 1'b1;
	logic chroma_twos = 1'b0;
	logic [SOURCE_PRIORITY_BUS_W-1:0] dev_id = 3'h2;
	logic dev_sw_req = 1'b1;
	logic dev_fb = 1'b0;
	logic [CONTRAST_W-1:0] main_con = 6'h20;
	logic [CONTRAST_W-1:0] side_con = 6'h10;
	logic [CONTRAST_W-1:0] rgb_con [RGB_COLOURS] = '{6'h20, 6'h20, 6'h00};
	logic colour_lookup_table_we = 1'b0;
	logic [3:0] colour_lookup_table_idx = 4'h0;
	logic [11:0] colour_lookup_table_data = 12'h000;
	logic disp_valid;
	logic [SOURCE_PRIORITY_BUS_W-1:0] disp_src;
	logic disp_is_rgb;
	logic [7:0] disp_y;
	logic [7:0] disp_c;
	logic [7:0] disp_rgb [RGB_COLOURS];
	logic dev_ack;
	logic fifo_underrun;
	logic [SOURCE_PRIORITY_BUS_W-1:0] src_id = 3'h5;
	logic src_sw_req = 1'b0;
	logic src_fb = 1'b0;
	logic src_is_rgb = 1'b0;
	logic [YC_W-1:0] src_yc = 16'hc35a;
	logic [RGB_W-1:0] src_rgb = 5'h00;
	logic [LINE_W-1:0] line_no;
	logic field_odd;
	logic src_ack;
	logic [7:0] py [8];
	logic [7:0] pc [8];
	logic [7:0] my;
	logic [7:0] mc;
	logic [SOURCE_PRIORITY_BUS_W-1:0] msrc;
	logic mdev;
	logic msrc_ack;
	logic [7:0] rg [3][3];
	logic ri [3];
	logic [RGB_W-1:0] rv [3];
	int ty [4] = '{0, 255, 128, 64};
	int tc [4] = '{64, -64, 64, 0};
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	pbpi_bus_if pbpi_bus_if_inst ();
	pbpi_device_end pbpi_device_end_inst (.clk(clk), .rst(rst), .bus(pbpi_bus_if_inst.device),
		.dec_valid(dec_valid), .dec_y(dec_y), .dec_c(dec_c), .dec_c_is_cr(dec_c_is_cr),
		.fe_active(fe_active), .dec_ready(dec_ready), .disp_line_start(disp_line_start),
		.disp_field_start(disp_field_start), .disp_field_odd(disp_field_odd),
		.chroma_twos(chroma_twos), .dev_id(dev_id), .dev_sw_req(dev_sw_req), .fast_blank(dev_fb),
		.main_contrast(main_con), .side_contrast(side_con), .rgb_contrast(rgb_con),
		.colour_lookup_table_we(colour_lookup_table_we), .colour_lookup_table_idx(colour_lookup_table_idx), .colour_lookup_table_data(colour_lookup_table_data), .disp_valid(disp_valid),
		.disp_src(disp_src), .disp_is_rgb(disp_is_rgb), .disp_y(disp_y), .disp_c(disp_c),
		.disp_rgb(disp_rgb), .dev_ack(dev_ack), .fifo_underrun(fifo_underrun));
	pbpi_source_end pbpi_source_end_inst (.clk(clk), .rst(rst), .bus(pbpi_bus_if_inst.source),
		.src_id(src_id), .src_sw_req(src_sw_req), .fast_blank(src_fb), .src_is_rgb(src_is_rgb),
		.src_yc(src_yc), .src_rgb(src_rgb), .line_start(), .line_no(line_no),
		.field_odd(field_odd), .pix_idx(), .src_ack(src_ack));
	pbpi_bus_chk pbpi_bus_chk_inst (.clk(clk), .rst(rst),
		.pix_strobe(pbpi_bus_if_inst.pix_strobe), .main_line_sync(pbpi_bus_if_inst.main_line_sync),
		.dev_source_priority_bus(pbpi_bus_if_inst.dev_source_priority_bus), .dev_source_priority_bus_oe(pbpi_bus_if_inst.dev_source_priority_bus_oe),
		.src_source_priority_bus(pbpi_bus_if_inst.src_source_priority_bus), .src_source_priority_bus_oe(pbpi_bus_if_inst.src_source_priority_bus_oe),
		.dev_yc_oe(pbpi_bus_if_inst.dev_yc_oe), .src_yc_oe(pbpi_bus_if_inst.src_yc_oe),
		.src_rgb_oe(pbpi_bus_if_inst.src_rgb_oe),
		.source_priority_bus(pbpi_bus_if_inst.source_priority_bus));
	always #2.5 clk = ~clk;
	// Five lines of about 10600 clocks each fit well under this ceiling.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] code_c(input int c, input bit cr, input bit twos);
		int v;
		v = (c * (cr ? int'(WEIGHT_CR_Q8) : int'(WEIGHT_CB_Q8)) * int'(CODE_GAIN)) >>> 15;
		return 8'(twos ? v : v + 128);
	endfunction
	// Fills the delay FIFO until it refuses; words outside the window must be dropped.
	task automatic push_words();
		int n;
		n = 0;
		dec_valid = 1'b1;
		dec_y = 8'h33;
		repeat (8) @(negedge clk);
		cmp({15'h0, dec_ready}, 16'h1);
		fe_active = 1'b1;
		while (dec_ready === 1'b1 && n < 8) begin
			dec_y = 8'(ty[n % 4]);
			dec_c = 8'(tc[n % 4]);
			dec_c_is_cr = n[0];
			@(negedge clk);
			n++;
		end
		dec_valid = 1'b0;
		fe_active = 1'b0;
		cmp(16'(n), 16'(FIFO_DEPTH));
	endtask
	task automatic run_line();
		int k;
		int idle;
		k = 0;
		idle = 0;
		disp_line_start = 1'b1;
		@(negedge clk);
		disp_line_start = 1'b0;
		while (idle < 40) begin
			@(negedge clk);
			idle++;
			if (disp_valid === 1'b1) begin
				if (k < 8) begin
					py[k] = disp_y;
					pc[k] = disp_c;
				end
				if (k == 500) begin
					{my, mc, msrc, mdev, msrc_ack} = {disp_y, disp_c, disp_src, dev_ack, src_ack};
				end
				if (k % 400 == 200) begin
					rg[k / 400] = disp_rgb;
					ri[k / 400] = disp_is_rgb;
				end
				src_rgb = rv[k / 400];
				k++;
				idle = 0;
			end
		end
		cmp(16'(k), 16'(ACTIVE_SAMPLES));
	endtask
	task automatic t_decode(input bit twos, input int ln);
		chroma_twos = twos;
		disp_field_odd = !twos;
		push_words();
		run_line();
		for (int i = 0; i < 4; i++) begin
			cmp({8'h0, py[i]}, {8'h0, 8'(((ty[i] * int'(CODE_GAIN)) >> 8) + 16)});
			cmp({8'h0, pc[i]}, {8'h0, code_c(tc[i], i[0], twos)});
		end
		cmp({py[4], pc[4]}, {CODE_OFS_Y, twos ? 8'h00 : CODE_OFS_C});
		cmp({12'h0, msrc, mdev}, {12'h0, dev_id, 1'b1});
		cmp({5'h0, field_odd, line_no}, {5'h0, !twos, FIRST_LINE + LINE_W'(ln)});
		cmp({15'h0, fifo_underrun}, 16'h1);
		$display("decode line with twos=%0d done", twos);
	endtask
	task automatic t_arb(input logic [SOURCE_PRIORITY_BUS_W-1:0] sid, input bit fb, input bit wins);
		src_id = sid;
		src_sw_req = !fb;
		src_fb = fb;
		dev_sw_req = !fb;
		dev_fb = fb;
		run_line();
		cmp({13'h0, msrc}, {13'h0, wins ? sid : dev_id});
		cmp({14'h0, mdev, msrc_ack}, {14'h0, !wins, wins});
		if (wins) begin
			cmp({8'h0, my}, 16'(int'(src_yc[15:8]) * side_con >> CONTRAST_SHIFT));
			cmp({8'h0, mc}, {8'h0, src_yc[7:0]});
		end
		src_sw_req = 1'b0;
		src_fb = 1'b0;
		dev_sw_req = 1'b1;
		dev_fb = 1'b0;
		$display("arbitration with source id %0d done", sid);
	endtask
	task automatic t_rgb();
		colour_lookup_table_idx = 4'h5;
		colour_lookup_table_data = 12'h0f0;
		colour_lookup_table_we = 1'b1;
		@(negedge clk);
		colour_lookup_table_we = 1'b0;
		src_id = 3'h6;
		src_sw_req = 1'b1;
		src_is_rgb = 1'b1;
		rv = '{5'h05, 5'h09, 5'h15};
		run_line();
		cmp({13'h0, rg[0][0] != 8'h0, rg[0][1] == 8'h0, rg[0][2] == 8'h0}, 16'h7);
		cmp({14'h0, rg[1][0] < rg[0][0], rg[1][0] != 8'h0}, 16'h3);
		cmp({13'h0, rg[2][0] == 8'h0, rg[2][1] != 8'h0, rg[2][2] == 8'h0}, 16'h7);
		cmp({13'h0, ri[0], ri[1], ri[2]}, 16'h7);
		src_sw_req = 1'b0;
		$display("rgb insertion done");
	endtask
	task automatic stop_test();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		rv = '{5'h00, 5'h00, 5'h00};
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_decode(1'b0, 0);
		t_decode(1'b1, 1);
		t_arb(3'h5, 1'b0, 1'b1);
		t_arb(3'h1, 1'b1, 1'b0);
		t_rgb();
		stop_test();
	end
endmodule // picture_bus_priority_interface_bench
`default_nettype wire
